// file: tb/baseband_source.sv
// Model of the baseband sample source that feeds the datapath.
`timescale 1ns/1ps
`default_nettype none
module baseband_source (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        en,
    input  wire logic [15:0] i_val,
    input  wire logic [15:0] q_val,
    input  wire logic        in_ready,
    output logic             in_valid,
    output logic      [15:0] in_i,
    output logic      [15:0] in_q
);
    logic        vld_r;
    logic [15:0] i_r;
    logic [15:0] q_r;

    // A pending sample is held until the datapath accepts it.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            vld_r <= 1'b0;
            i_r   <= 16'h0000;
            q_r   <= 16'h0000;
        end else if (!vld_r || in_ready) begin
            vld_r <= #1 en;
            i_r   <= #1 i_val;
            q_r   <= #1 q_val;
        end
    end

    // Idle lines show the inverse of the last word, never a stale copy.
    assign in_valid = vld_r;
    assign in_i     = vld_r ? i_r : ~i_r;
    assign in_q     = vld_r ? q_r : ~q_r;
endmodule
`default_nettype wire

// file: tb/test_interp_modulator_datapath.sv
// Self-checking testbench for the interpolating modulator datapath.
`timescale 1ns/1ps
`default_nettype none
module test_interp_modulator_datapath
    import interp_mod_pkg::*;
;
    typedef struct {logic [7:0] cfg; int a; int b; int gap;} row_t;
    logic        core_clk, rst_b, reg_wr, in_valid, in_ready, src_en;
    logic        data_clk_en, dac_strobe, underrun;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [15:0] in_i, in_q, dac_i, dac_q, src_i, src_q;
    int          err_count = 0;
    int          checked = 0;
    int          si[16], sq[16], n;
    bit          ok;
    int          tab8[8] = '{0, 46341, 65536, 46341, 0, -46341, -65536, 46341};
    row_t        rows[11] = '{
        '{8'h00, 1000, -300, 1}, '{8'h10, 1000, -300, 1},
        '{8'h50, 1000, -300, 2}, '{8'ha0, 1000, -300, 4},
        '{8'hf0, 1000, -300, 8}, '{8'h18, 1000, -300, 2},
        '{8'hc8, 1000, -300, 16}, '{8'h24, 1000, -300, 1},
        '{8'h26, 1000, -300, 1}, '{8'h34, 1000, 0, 1},
        '{8'h36, 1000, 0, 1}};

    interp_modulator_datapath u_dut (.core_clk(core_clk), .rst_b(rst_b),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready),
        .in_i(in_i), .in_q(in_q), .data_clk_en(data_clk_en),
        .dac_i(dac_i), .dac_q(dac_q), .dac_strobe(dac_strobe),
        .underrun(underrun));
    baseband_source u_src (.core_clk(core_clk), .rst_b(rst_b), .en(src_en),
        .i_val(src_i), .q_val(src_q), .in_ready(in_ready),
        .in_valid(in_valid), .in_i(in_i), .in_q(in_q));

    // -----------------------------------------------------------------
    // Clock, watchdog and reporting
    // -----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        results();
    end

    task automatic check(input string name, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] addr, data);
        @(posedge core_clk);
        #1 reg_wr = 1'b1;
        reg_addr = addr;
        reg_wdata = data;
        @(posedge core_clk);
        #1 reg_wr = 1'b0;
    endtask

    // Carrier weight in Q16 for a slot index of the selected frequency.
    function automatic int coef(logic [1:0] f, int k);
        case (f)
            2'b00: return 65536;
            2'b01: return k[0] ? -65536 : 65536;
            2'b10: return k[0] ? ((k % 4 == 1) ? 65536 : -65536) : 0;
            default: return tab8[k % 8];
        endcase
    endfunction

    // Expected converter word at slot k for one channel.
    function automatic int expv(logic [7:0] c, int a, b, k, bit qch);
        int m, p, cs, sn;
        if (c[3] && k[0]) return -32768;
        m = c[3] ? k / 2 : k;
        p = (c[5:4] == 2'b11) ? 2 : 1;
        cs = coef(c[5:4], m + 16);
        sn = coef(c[5:4], m + 16 - p) * (c[1] ? -1 : 1);
        if (!c[2]) return ((qch ? b : a) * cs) >>> 16;
        return qch ? (a * sn + b * cs) >>> 16 : (a * cs - b * sn) >>> 16;
    endfunction

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h01;
        reg_wdata = 8'h00;
        src_en = 1'b0;
        src_i = 16'h0000;
        src_q = 16'h0000;
        repeat (5) @(posedge core_clk);
        #1 rst_b = 1'b1;
        @(negedge core_clk);
        check("mode_reset", reg_rdata, 8'h00);
        check("ready_reset", in_ready, 1'b1);
        wr_reg(8'h02, 8'hff);
        reg_addr = 8'h02;
        @(negedge core_clk);
        check("unmapped_read", reg_rdata, 8'h00);
        @(posedge core_clk);
        #1 reg_addr = 8'h01;
        src_en = 1'b1;
        @(negedge core_clk);
        check("refused_write", reg_rdata, 8'h00);
        // Each row sets a mode, lets the queue settle, then matches a run.
        foreach (rows[r]) begin
            wr_reg(8'h01, rows[r].cfg);
            src_i = rows[r].a[15:0];
            src_q = rows[r].b[15:0];
            @(negedge core_clk);
            check("mode_read", reg_rdata, rows[r].cfg);
            repeat (300) @(negedge core_clk);
            for (int k = 0; k < 16; k++) begin
                @(negedge core_clk);
                si[k] = $signed(dac_i);
                sq[k] = $signed(dac_q);
            end
            check("strobe", dac_strobe, 1'b1);
            ok = 0;
            for (int p = 0; p < 16; p++) begin
                n = 0;
                for (int k = 0; k < 16; k++) begin
                    if ((si[k] - expv(rows[r].cfg, rows[r].a, rows[r].b,
                         k + p, 0)) ** 2 > 1) n++;
                    if ((sq[k] - expv(rows[r].cfg, rows[r].a, rows[r].b,
                         k + p, 1)) ** 2 > 1) n++;
                end
                if (n == 0) ok = 1;
            end
            check("dac_seq", ok, 1);
            n = 0;
            while (data_clk_en !== 1'b1 && n < 40) begin
                @(negedge core_clk);
                n++;
            end
            n = 0;
            do begin
                @(negedge core_clk);
                n++;
            end while (data_clk_en !== 1'b1 && n < 40);
            check("sample_gap", n, rows[r].gap);
            $display("mode %h done", rows[r].cfg);
        end
        // Slowest drain: the queue must fill, refuse, then run dry.
        wr_reg(8'h01, 8'hc8);
        n = 0;
        while (in_ready !== 1'b0 && n < 60) begin
            @(negedge core_clk);
            n++;
        end
        check("fifo_full", in_ready, 1'b0);
        @(posedge core_clk);
        #1 src_en = 1'b0;
        n = 0;
        while (underrun !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        check("underrun", underrun, 1'b1);
        check("fifo_empty", in_ready, 1'b1);
        $display("fill and drain done");
        // A second reset must clear the mode register and the outputs.
        @(posedge core_clk);
        #1 rst_b = 1'b0;
        reg_addr = 8'h01;
        @(negedge core_clk);
        check("mode_rereset", reg_rdata, 8'h00);
        check("strobe_rereset", dac_strobe, 1'b0);
        @(posedge core_clk);
        #1 rst_b = 1'b1;
        repeat (2) @(negedge core_clk);
        check("strobe_release", dac_strobe, 1'b1);
        check("dac_release", dac_i, 16'h0000);
        $display("second reset done");
        results();
    end
endmodule
`default_nettype wire

// file: verilog/interp_mod_cfg.svh
// Constants for the interpolating modulator datapath.
// How it works
// [R01] Bits 7:6 pick 2x, 4x or 8x.
// [R02] Half-rate carrier multiplies by 1, -1.
// [R03] Quarter-rate carrier is 0, 1, 0, -1.
// [R04] Eighth-rate carrier kept as printed, last positive.
// [R05] Interpolation runs ahead of the modulator.
// [R06] Bit 3 switches zero stuffing on.
// [R07] Stuffing inserts one midscale word per sample.
// [R08] Stuffing doubles converter rate over input rate.
// [R09] Stuffing sits after modulator, before converter.
// [R10] Bit 2 couples I and Q into complex.
// [R11] Bit 1 selects rotation sign.
// [R12] Positive rotation: cosine real, sine imaginary.
// [R13] Carrier at half, quarter or eighth rate.
// [R14] Field 00 bypasses interpolation.
// [R15] Bits 5:4 select modulation frequency.
// [R16] Software avoids complex mode at half rate.
// [R17] Stuffing doubles the input clock divider.
// [R18] Complex outputs: Icos-Qsin and Isin+Qcos.
// [R19] Carriers follow selection; off passes unchanged.
`ifndef INTERP_MOD_CFG_SVH
`define INTERP_MOD_CFG_SVH
`define MODE_REG_ADDR    8'h01
`define MODE_REG_RESET   8'h00
`define INTERP_MSB       7
`define INTERP_LSB       6
`define MODF_MSB         5
`define MODF_LSB         4
`define STUFF_BIT        3
`define CPLX_BIT         2
`define NEG_ROT_BIT      1
`define MIDSCALE_WORD    16'h8000
`define COEF_0707        18'sh0b505
`define COEF_ONE         18'sh10000
`define FIFO_DEPTH       16
`endif

// file: verilog/interp_mod_pkg.sv
// Types for the interpolating modulator datapath.
package interp_mod_pkg;
    typedef enum logic [1:0] {
        INTERP_1X = 2'b00,
        INTERP_2X = 2'b01,
        INTERP_4X = 2'b10,
        INTERP_8X = 2'b11
    } interp_t;
    typedef enum logic [1:0] {
        MOD_OFF   = 2'b00,
        MOD_HALF  = 2'b01,
        MOD_QUART = 2'b10,
        MOD_EIGHT = 2'b11
    } modf_t;
    typedef enum logic [0:0] {
        PH_DATA  = 1'b0,
        PH_STUFF = 1'b1
    } stuff_t;
endpackage

// file: verilog/interp_modulator_datapath.sv
// Interpolating I/Q modulator datapath with sample FIFO and zero stuffing.
`timescale 1ns/1ps
`default_nettype none
`include "interp_mod_cfg.svh"

// ------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------
module sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    // Handshakes are honest: full and empty come from the count.
    // Ready while a slot is free; the count only reaches DEPTH when full.
    assign in_ready  = (cnt_r < (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rd_r];

    // Storage written by index.
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    // Pointers and fill count.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// ------------------------------------------------------------
// Datapath top
// ------------------------------------------------------------
module interp_modulator_datapath
    import interp_mod_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic [15:0] in_i,
    input  wire logic [15:0] in_q,
    output logic             data_clk_en,
    output logic      [15:0] dac_i,
    output logic      [15:0] dac_q,
    output logic             dac_strobe,
    output logic             underrun
);
    logic [7:0]  mode_r;
    interp_t     interp;
    modf_t       modf;
    logic        stuff_en;
    logic        cplx_en;
    logic        neg_rot;
    logic        f_valid;
    logic        f_ready;
    logic [31:0] f_data;
    logic [3:0]  div_r;
    logic [3:0]  div_top;
    logic [2:0]  phase_r;
    stuff_t      st_r;
    logic signed [15:0] hold_i_r;
    logic signed [15:0] hold_q_r;
    logic signed [17:0] cos_c;
    logic signed [17:0] sin_c;
    logic signed [33:0] mi;
    logic signed [33:0] mq;
    logic signed [15:0] yi;
    logic signed [15:0] yq;

    // Control register decode.
    assign interp   = interp_t'(mode_r[`INTERP_MSB:`INTERP_LSB]); // R01
    assign modf     = modf_t'(mode_r[`MODF_MSB:`MODF_LSB]);       // R15
    assign stuff_en = mode_r[`STUFF_BIT];                         // R06
    assign cplx_en  = mode_r[`CPLX_BIT];                          // R10
    assign neg_rot  = mode_r[`NEG_ROT_BIT];                       // R11
    assign reg_rdata = (reg_addr == `MODE_REG_ADDR) ? mode_r : 8'h00;

    // Register write port.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= `MODE_REG_RESET;
        end else if (reg_wr && reg_addr == `MODE_REG_ADDR) begin
            mode_r <= reg_wdata;
        end
    end

    // Incoming samples queue here until the next input-rate slot.
    sample_fifo #(.WIDTH(32), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   ({in_i, in_q}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    // Converter cycles per input sample: interpolation, doubled by stuffing.
    always_comb begin
        case (interp)
            INTERP_1X: div_top = 4'd0;  // R14
            INTERP_2X: div_top = 4'd1;  // R01
            INTERP_4X: div_top = 4'd3;
            INTERP_8X: div_top = 4'd7;
            default:   div_top = 4'd0;
        endcase
        if (stuff_en) begin
            div_top = {div_top[2:0], 1'b1}; // R17 R08
        end
    end

    // Input data rate divider: one enable pulse per input sample.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_r <= 4'd0;
        end else begin
            div_r <= (div_r >= div_top) ? 4'd0 : div_r + 4'd1;
        end
    end
    assign data_clk_en = (div_r == 4'd0);
    assign f_ready     = data_clk_en;
    assign underrun    = data_clk_en && !f_valid;

    // Interpolator: zero-order hold stands in for the half-band chain.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_i_r <= 16'sh0000;
            hold_q_r <= 16'sh0000;
        end else if (data_clk_en && f_valid) begin
            hold_i_r <= f_data[31:16]; // R05
            hold_q_r <= f_data[15:0];
        end
    end

    // Stuffing phase alternates data and midscale words.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= PH_DATA;
        end else if (!stuff_en) begin
            st_r <= PH_DATA;
        end else begin
            case (st_r)
                PH_DATA:  st_r <= PH_STUFF; // R07
                PH_STUFF: st_r <= PH_DATA;
                default:  st_r <= PH_DATA;
            endcase
        end
    end

    // Carrier phase advances once per modulated sample.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_r <= 3'd0;
        end else if (st_r == PH_DATA) begin
            phase_r <= phase_r + 3'd1;
        end
    end

    // Carrier tables; at quarter and eighth rate the sine is the cosine delayed a quarter turn.
    always_comb begin
        cos_c = `COEF_ONE;
        sin_c = 18'sh00000;
        case (modf)
            MOD_OFF: begin
                cos_c = `COEF_ONE;                           // R19
                sin_c = 18'sh00000;
            end
            MOD_HALF: begin
                cos_c = phase_r[0] ? -`COEF_ONE : `COEF_ONE; // R02 R13
                sin_c = 18'sh00000;                          // R16
            end
            MOD_QUART: begin
                case (phase_r[1:0])                          // R03
                    2'd0: begin cos_c = 18'sh00000; sin_c = -`COEF_ONE; end
                    2'd1: begin cos_c = `COEF_ONE; sin_c = 18'sh00000; end
                    2'd2: begin cos_c = 18'sh00000; sin_c = `COEF_ONE; end
                    default: begin cos_c = -`COEF_ONE; sin_c = 18'sh00000; end
                endcase
            end
            MOD_EIGHT: begin
                case (phase_r)                               // R04
                    3'd0: begin cos_c = 18'sh00000; sin_c = -`COEF_ONE; end
                    3'd1: begin cos_c = `COEF_0707; sin_c = `COEF_0707; end
                    3'd2: begin cos_c = `COEF_ONE;  sin_c = 18'sh00000; end
                    3'd3: begin cos_c = `COEF_0707; sin_c = `COEF_0707; end
                    3'd4: begin cos_c = 18'sh00000; sin_c = `COEF_ONE; end
                    3'd5: begin cos_c = -`COEF_0707; sin_c = `COEF_0707; end
                    3'd6: begin cos_c = -`COEF_ONE; sin_c = 18'sh00000; end
                    default: begin cos_c = `COEF_0707; sin_c = -`COEF_0707; end
                endcase
            end
            default: begin
                cos_c = `COEF_ONE;
                sin_c = 18'sh00000;
            end
        endcase
    end

    // Real mode multiplies each channel by the carrier alone;
    // complex mode rotates the I/Q pair.
    always_comb begin
        if (cplx_en) begin
            if (!neg_rot) begin
                mi = hold_i_r * cos_c - hold_q_r * sin_c; // R12 R18
                mq = hold_i_r * sin_c + hold_q_r * cos_c;
            end else begin
                mi = hold_i_r * cos_c + hold_q_r * sin_c; // R11 R18
                mq = hold_q_r * cos_c - hold_i_r * sin_c;
            end
        end else begin
            mi = hold_i_r * cos_c;                        // R13
            mq = hold_q_r * cos_c;
        end
        yi = mi[31:16];
        yq = mq[31:16];
    end

    // Converter words: midscale in stuff slots, modulated data otherwise.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dac_i      <= 16'h0000;
            dac_q      <= 16'h0000;
            dac_strobe <= 1'b0;
        end else begin
            dac_strobe <= 1'b1;
            if (st_r == PH_STUFF) begin
                dac_i <= `MIDSCALE_WORD; // R09 R07
                dac_q <= `MIDSCALE_WORD;
            end else begin
                dac_i <= yi;
                dac_q <= yq;
            end
        end
    end

    // Stuffed slots always carry the midscale word.
    a_stuff_midscale: assert property ( // R07
        @(posedge core_clk) disable iff (!rst_b)
        ($past(st_r) == PH_STUFF && $past(rst_b)) |-> dac_i == 16'h8000)
        else $error("Stuff slot not midscale.");
    // Stuffing alternates with data.
    a_stuff_alt: assert property ( // R06
        @(posedge core_clk) disable iff (!rst_b)
        (stuff_en && st_r == PH_DATA) |=> (st_r == PH_STUFF || !stuff_en))
        else $error("Stuff phase did not alternate.");
    // Disabled stuffing never inserts.
    a_stuff_off: assert property ( // R09
        @(posedge core_clk) disable iff (!rst_b)
        !stuff_en |=> st_r == PH_DATA)
        else $error("Stuffing while disabled.");
    // Divider period in 2x without stuffing is two.
    a_div_2x: assert property ( // R01
        @(posedge core_clk) disable iff (!rst_b)
        (data_clk_en && interp == INTERP_2X && !stuff_en)[*2] |-> 1'b0)
        else $error("2x divider pulsed back to back.");
    // Bypass without stuffing gives an enable every cycle.
    a_bypass_rate: assert property ( // R14
        @(posedge core_clk) disable iff (!rst_b)
        (interp == INTERP_1X && !stuff_en && div_r == 4'd0) |=> data_clk_en)
        else $error("Bypass rate wrong.");
    // Stuffing doubles the 8x divider.
    a_div_stuff: assert property ( // R17
        @(posedge core_clk) disable iff (!rst_b)
        (stuff_en && interp == INTERP_8X) |-> div_top == 4'd15)
        else $error("Stuffed divider not doubled.");
    // Half-rate carrier flips sign on alternate samples.
    a_half_sign: assert property ( // R02
        @(posedge core_clk) disable iff (!rst_b)
        (modf == MOD_HALF && phase_r[0]) |-> cos_c == -`COEF_ONE)
        else $error("Half-rate sign wrong.");
    // Quarter-rate carrier zero at even phases.
    a_quart_zero: assert property ( // R03
        @(posedge core_clk) disable iff (!rst_b)
        (modf == MOD_QUART && !phase_r[0]) |-> cos_c == 18'sh00000)
        else $error("Quarter-rate zero missing.");
    // Modulation off leaves real samples unchanged.
    a_mod_pass: assert property ( // R19
        @(posedge core_clk) disable iff (!rst_b)
        (modf == MOD_OFF && !cplx_en) |-> yi == hold_i_r)
        else $error("Pass-through altered sample.");
    // A popped sample reaches the hold stage on the next edge.
    a_hold_load: assert property ( // R05
        @(posedge core_clk) disable iff (!rst_b)
        (data_clk_en && f_valid) |=> hold_i_r == $past(f_data[31:16]))
        else $error("Popped sample not held.");
    // An empty slot keeps the previous sample rather than garbage.
    a_hold_keep: assert property ( // R05
        @(posedge core_clk) disable iff (!rst_b)
        underrun |=> $stable(hold_i_r))
        else $error("Held sample changed on underrun.");
    // Eighth-rate sine lags the cosine by two phases.
    a_eight_sine: assert property ( // R04
        @(posedge core_clk) disable iff (!rst_b)
        (modf == MOD_EIGHT && phase_r == 3'd0) |-> sin_c == -`COEF_ONE)
        else $error("Eighth-rate sine phase wrong.");
    // The rotation sign flips the quadrature term of the real output.
    a_cplx_sign: assert property ( // R11
        @(posedge core_clk) disable iff (!rst_b)
        (cplx_en && modf == MOD_QUART && phase_r[1:0] == 2'd0) |->
        yi == (neg_rot ? -hold_q_r : hold_q_r))
        else $error("Complex rotation sign wrong.");
endmodule
`default_nettype wire
